// [csi_port1_hs_timing_consts.vh]
`ifndef CSI_PORT1_HS_TIMING_CONSTS_VH
`define CSI_PORT1_HS_TIMING_CONSTS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_HS_ZERO       8'h65
`define IDX_HS_TRAIL      8'h66
`define IDX_HS_EXIT       8'h67
`define IDX_PLX           8'h68
`define IDX_RSVD_FIRST    8'h69
`define IDX_RSVD_LAST     8'h71
`define IDX_LANE_RATE     8'h72

// ----------------------------------------
// Field layout
// ----------------------------------------
`define OVR_BIT           7
`define VAL_MSB           6
`define RATE_MSB          1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_OVR           1'b0
`define RST_RATE          2'h0
`define RST_BYTE          8'h00

// ----------------------------------------
// Lane rate codes
// ----------------------------------------
`define RATE_800          2'h0
`define RATE_400          2'h1
`define RATE_1200         2'h2
`define RATE_1600         2'h3

// ----------------------------------------
// Automatic timing values per lane rate
// ----------------------------------------
`define AUTO_ZERO_800     7'h0c
`define AUTO_TRAIL_800    7'h08
`define AUTO_EXIT_800     7'h0b
`define AUTO_PLX_800      7'h06
`define AUTO_ZERO_400     7'h06
`define AUTO_TRAIL_400    7'h04
`define AUTO_EXIT_400     7'h06
`define AUTO_PLX_400      7'h03
`define AUTO_ZERO_1200    7'h12
`define AUTO_TRAIL_1200   7'h0c
`define AUTO_EXIT_1200    7'h11
`define AUTO_PLX_1200     7'h09
`define AUTO_ZERO_1600    7'h18
`define AUTO_TRAIL_1600   7'h10
`define AUTO_EXIT_1600    7'h16
`define AUTO_PLX_1600     7'h0c

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// [csi_port1_hs_timing_override.v]
// Behaviour
// - Hs-zero override clear: hs-zero comes from the automatic value.
// - Hs-zero override set: hs-zero is the software field, reset 0x0c.
// - Hs-trail override clear: hs-trail comes from the automatic value.
// - Hs-trail override set: hs-trail is the software field, reset 0x08.
// - Hs-exit override clear: hs-exit comes from the automatic value.
// - Hs-exit override set: hs-exit is the software field, reset 0x0b.
// - Plx override clear: plx comes from the automatic value.
// - Plx override set: plx is the software field, reset 0x06.
// - Override clear: bits 6:0 read back the automatic value in use.
// - Override set: bits 6:0 are readable and writable.
// - Resets match 800 Mbps; automatic values follow the selected lane rate.
// - Indices 0x69 to 0x71 are reserved, read zero, no function.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "csi_port1_hs_timing_consts.vh"

module csi_port1_hs_timing_override
(
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [6:0]  hs_zero_time,
    output reg  [6:0]  hs_trail_time,
    output reg  [6:0]  hs_exit_time,
    output reg  [6:0]  plx_time
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg        hs_zero_override;
    reg        hs_trail_override;
    reg        hs_exit_override;
    reg        plx_override;
    reg [6:0]  hs_zero_value;
    reg [6:0]  hs_trail_value;
    reg [6:0]  hs_exit_value;
    reg [6:0]  plx_value;
    reg [1:0]  lane_rate;
    reg        aw_held;
    reg        w_held;
    reg [31:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    reg [6:0]  auto_zero;
    reg [6:0]  auto_trail;
    reg [6:0]  auto_exit;
    reg [6:0]  auto_plx;
    reg [6:0]  next_zero;
    reg [6:0]  next_trail;
    reg [6:0]  next_exit;
    reg [6:0]  next_plx;
    reg [7:0]  rd_byte;
    reg        rd_ok;

    wire       do_write;
    wire [7:0] wr_idx;
    wire       wr_aligned;
    wire       wr_lane0;
    wire [7:0] wr_byte;
    wire [7:0] rd_idx;
    wire       rd_aligned;
    wire       wr_ok;

    // ----------------------------------------
    // Handshake and decode
    // ----------------------------------------
    // Address and data taken independently, written once both are held
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_write      = aw_held & w_held & ~s_axi_bvalid;
    assign wr_idx        = aw_addr[9:2];
    assign wr_aligned    = (aw_addr[31:10] == 22'h000000);
    assign wr_lane0      = w_strb[0];
    assign wr_byte       = w_data[7:0];
    assign rd_idx        = s_axi_araddr[9:2];
    assign rd_aligned    = (s_axi_araddr[31:10] == 22'h000000);
    assign wr_ok         = wr_aligned & (wr_idx >= `IDX_HS_ZERO) & (wr_idx <= `IDX_LANE_RATE);

    // ----------------------------------------
    // Automatic values from lane rate
    // ----------------------------------------
    // Lookup of derived timings per selected rate
    always @*
    begin
        case (lane_rate)
            `RATE_800:
            begin
                auto_zero  = `AUTO_ZERO_800;
                auto_trail = `AUTO_TRAIL_800;
                auto_exit  = `AUTO_EXIT_800;
                auto_plx   = `AUTO_PLX_800;
            end
            `RATE_400:
            begin
                auto_zero  = `AUTO_ZERO_400;
                auto_trail = `AUTO_TRAIL_400;
                auto_exit  = `AUTO_EXIT_400;
                auto_plx   = `AUTO_PLX_400;
            end
            `RATE_1200:
            begin
                auto_zero  = `AUTO_ZERO_1200;
                auto_trail = `AUTO_TRAIL_1200;
                auto_exit  = `AUTO_EXIT_1200;
                auto_plx   = `AUTO_PLX_1200;
            end
            default:
            begin
                auto_zero  = `AUTO_ZERO_1600;
                auto_trail = `AUTO_TRAIL_1600;
                auto_exit  = `AUTO_EXIT_1600;
                auto_plx   = `AUTO_PLX_1600;
            end
        endcase
    end

    // ----------------------------------------
    // Effective timing selection
    // ----------------------------------------
    // Override picks software field, else automatic value
    always @*
    begin
        next_zero  = hs_zero_override  ? hs_zero_value  : auto_zero;
        next_trail = hs_trail_override ? hs_trail_value : auto_trail;
        next_exit  = hs_exit_override  ? hs_exit_value  : auto_exit;
        next_plx   = plx_override      ? plx_value      : auto_plx;
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    // Fields read as the timing in use; reserved reads zero
    always @*
    begin
        rd_byte = `RST_BYTE;
        rd_ok   = rd_aligned;
        case (rd_idx)
            `IDX_HS_ZERO:   rd_byte = {hs_zero_override, next_zero};
            `IDX_HS_TRAIL:  rd_byte = {hs_trail_override, next_trail};
            `IDX_HS_EXIT:   rd_byte = {hs_exit_override, next_exit};
            `IDX_PLX:       rd_byte = {plx_override, next_plx};
            `IDX_LANE_RATE: rd_byte = {6'h00, lane_rate};
            default:
            begin
                if ((rd_idx < `IDX_RSVD_FIRST) || (rd_idx > `IDX_RSVD_LAST))
                begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    // ----------------------------------------
    // Write channel and registers
    // ----------------------------------------
    // Captures address and data, updates fields, issues response
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held           <= 1'b0;
            w_held            <= 1'b0;
            aw_addr           <= 32'h00000000;
            w_data            <= 32'h00000000;
            w_strb            <= 4'h0;
            s_axi_bvalid      <= 1'b0;
            s_axi_bresp       <= `RESP_OKAY;
            hs_zero_override  <= `RST_OVR;
            hs_trail_override <= `RST_OVR;
            hs_exit_override  <= `RST_OVR;
            plx_override      <= `RST_OVR;
            hs_zero_value     <= `AUTO_ZERO_800;
            hs_trail_value    <= `AUTO_TRAIL_800;
            hs_exit_value     <= `AUTO_EXIT_800;
            plx_value         <= `AUTO_PLX_800;
            lane_rate         <= `RST_RATE;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                if (wr_ok && wr_lane0)
                begin
                    case (wr_idx)
                        `IDX_HS_ZERO:
                        begin
                            hs_zero_override <= wr_byte[`OVR_BIT];
                            if (wr_byte[`OVR_BIT])
                                hs_zero_value <= wr_byte[`VAL_MSB:0];
                        end
                        `IDX_HS_TRAIL:
                        begin
                            hs_trail_override <= wr_byte[`OVR_BIT];
                            if (wr_byte[`OVR_BIT])
                                hs_trail_value <= wr_byte[`VAL_MSB:0];
                        end
                        `IDX_HS_EXIT:
                        begin
                            hs_exit_override <= wr_byte[`OVR_BIT];
                            if (wr_byte[`OVR_BIT])
                                hs_exit_value <= wr_byte[`VAL_MSB:0];
                        end
                        `IDX_PLX:
                        begin
                            plx_override <= wr_byte[`OVR_BIT];
                            if (wr_byte[`OVR_BIT])
                                plx_value <= wr_byte[`VAL_MSB:0];
                        end
                        `IDX_LANE_RATE: lane_rate <= wr_byte[`RATE_MSB:0];
                        default:        lane_rate <= lane_rate; // Reserved writes dropped
                    endcase
                end
            end
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    // One-cycle registered read answer
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
                s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Timing outputs
    // ----------------------------------------
    // Registered timings toward the lane transmitter
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hs_zero_time  <= `AUTO_ZERO_800;
            hs_trail_time <= `AUTO_TRAIL_800;
            hs_exit_time  <= `AUTO_EXIT_800;
            plx_time      <= `AUTO_PLX_800;
        end
        else if (ce)
        begin
            hs_zero_time  <= next_zero;
            hs_trail_time <= next_trail;
            hs_exit_time  <= next_exit;
            plx_time      <= next_plx;
        end
    end

endmodule

// [csi_port1_hs_timing_checker.sv]
`timescale 1ns/1ps
`include "csi_port1_hs_timing_consts.vh"

module csi_port1_hs_timing_checker
(
    input wire        aclk,
    input wire        aresetn,
    input wire        ce,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [6:0]  hs_zero_time,
    input wire [6:0]  hs_trail_time,
    input wire [6:0]  hs_exit_time,
    input wire [6:0]  plx_time
);
    reg rsv;

    // Marks a read aimed at the reserved range
    always @(posedge aclk)
    begin
        if (!aresetn)
            rsv <= 1'b0;
        else if (ce && s_axi_arvalid && s_axi_arready)
            rsv <= s_axi_araddr[31:10] == 22'h0 && s_axi_araddr[9:2] >= `IDX_RSVD_FIRST
                   && s_axi_araddr[9:2] <= `IDX_RSVD_LAST;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_rd_lat; ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_wr_lat; ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready ##1 ce
        |=> s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_wrdy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_wrdy: assert property (p_wrdy) else $error("write taken during answer");
    property p_rsv; s_axi_rvalid && rsv |-> s_axi_rdata == 32'h0 && s_axi_rresp == `RESP_OKAY; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved read not zero");
    property p_rst; $rose(aresetn) |-> {hs_zero_time, hs_trail_time, hs_exit_time, plx_time}
        == {7'h0c, 7'h08, 7'h0b, 7'h06}; endproperty
    a_rst: assert property (p_rst) else $error("timing reset wrong");
    property p_chg; $past(aresetn) && $changed(hs_zero_time) |-> $past(s_axi_bvalid); endproperty
    a_chg: assert property (p_chg) else $error("timing moved without write");

    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata[7]);
    cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule

bind csi_port1_hs_timing_override csi_port1_hs_timing_checker csi_port1_hs_timing_checker_inst
(
    .aclk          (aclk),
    .aresetn       (aresetn),
    .ce            (ce),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .hs_zero_time  (hs_zero_time),
    .hs_trail_time (hs_trail_time),
    .hs_exit_time  (hs_exit_time),
    .plx_time      (plx_time)
);

// [tb_top.sv]
`timescale 1ns/1ps
`include "csi_port1_hs_timing_consts.vh"

module tb_top;
    reg         aclk, aresetn, ce;
    reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
    reg  [3:0]  s_axi_wstrb;
    reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [6:0]  hs_zero_time, hs_trail_time, hs_exit_time, plx_time;
    wire [27:0] outs = {hs_zero_time, hs_trail_time, hs_exit_time, plx_time};
    integer     bad_count = 0;
    integer     num_checks = 0;
    reg  [7:0]  i, r;

    csi_port1_hs_timing_override csi_port1_hs_timing_override_inst
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .ce            (ce),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .hs_zero_time  (hs_zero_time),
        .hs_trail_time (hs_trail_time),
        .hs_exit_time  (hs_exit_time),
        .plx_time      (plx_time)
    );

    // Clock
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task summarize;
    begin
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask

    task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            bad_count = bad_count + 1;
        end
    end
    endtask

    task tmo;
    begin
        $display("MISMATCH wait expected answer seen none");
        bad_count = bad_count + 1;
        summarize;
    end
    endtask

    // Automatic value per rate and register
    function [6:0] av(input [1:0] rt, input [1:0] k);
        reg [27:0] t;
    begin
        case (rt)
            `RATE_800:  t = {`AUTO_ZERO_800, `AUTO_TRAIL_800, `AUTO_EXIT_800, `AUTO_PLX_800};
            `RATE_400:  t = {`AUTO_ZERO_400, `AUTO_TRAIL_400, `AUTO_EXIT_400, `AUTO_PLX_400};
            `RATE_1200: t = {`AUTO_ZERO_1200, `AUTO_TRAIL_1200, `AUTO_EXIT_1200, `AUTO_PLX_1200};
            default:    t = {`AUTO_ZERO_1600, `AUTO_TRAIL_1600, `AUTO_EXIT_1600, `AUTO_PLX_1600};
        endcase
        av = t[27 - 7 * k -: 7];
    end
    endfunction

    task co(input [1:0] k, input [31:0] e);
        chk("timing", 32'(outs[27 - 7 * k -: 7]), e);
    endtask

    // AXI4-Lite write, response ready raised with the request
    task wr(input [7:0] idx, input [7:0] d, input [1:0] er);
        integer n;
        reg     done;
    begin
        done = 1'b0;
        s_axi_awaddr <= {22'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40 && !done; n = n + 1)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                done = 1'b1;
                chk("bresp", 32'(s_axi_bresp), 32'(er));
                s_axi_bready <= 1'b0;
            end
        end
        if (!done)
            tmo;
        @(posedge aclk);
    end
    endtask

    // AXI4-Lite read, read ready raised with the request
    task rd(input [7:0] idx, input [31:0] ed, input [1:0] er);
        integer n;
        reg     done;
    begin
        done = 1'b0;
        s_axi_araddr <= {22'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40 && !done; n = n + 1)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                done = 1'b1;
                chk("rdata", s_axi_rdata, ed);
                chk("rresp", 32'(s_axi_rresp), 32'(er));
                s_axi_rready <= 1'b0;
            end
        end
        if (!done)
            tmo;
        @(posedge aclk);
    end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            rd(`IDX_HS_ZERO + i, 32'(av(`RATE_800, i[1:0])), `RESP_OKAY);
            co(i[1:0], 32'(av(`RATE_800, i[1:0])));
        end
        $display("test reset done");
    end
    endtask

    task t_override;
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(`IDX_HS_ZERO + i, 8'hd1 + i, `RESP_OKAY);
            co(i[1:0], 32'h51 + i);
            rd(`IDX_HS_ZERO + i, 32'hd1 + i, `RESP_OKAY);
            wr(`IDX_HS_ZERO + i, 8'h2a, `RESP_OKAY);
            co(i[1:0], 32'(av(`RATE_800, i[1:0])));
            rd(`IDX_HS_ZERO + i, 32'(av(`RATE_800, i[1:0])), `RESP_OKAY);
        end
        $display("test override done");
    end
    endtask

    task t_rate;
    begin
        for (r = 1; r < 5; r = r + 1)
        begin
            wr(`IDX_LANE_RATE, {6'h0, r[1:0]}, `RESP_OKAY);
            for (i = 0; i < 4; i = i + 1)
            begin
                rd(`IDX_HS_ZERO + i, 32'(av(r[1:0], i[1:0])), `RESP_OKAY);
                co(i[1:0], 32'(av(r[1:0], i[1:0])));
            end
        end
        $display("test rate done");
    end
    endtask

    task t_map;
    begin
        for (i = `IDX_RSVD_FIRST; i <= `IDX_RSVD_LAST; i = i + 1)
        begin
            wr(i, 8'hff, `RESP_OKAY);
            rd(i, 32'h0, `RESP_OKAY);
        end
        s_axi_wstrb <= 4'he;
        wr(`IDX_HS_ZERO, 8'hff, `RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(`IDX_HS_ZERO, 32'h0c, `RESP_OKAY);
        wr(8'h73, 8'h8f, `RESP_SLVERR);
        rd(8'h73, 32'h0, `RESP_SLVERR);
        rd(8'h64, 32'h0, `RESP_SLVERR);
        for (i = 0; i < 4; i = i + 1)
            co(i[1:0], 32'(av(`RATE_800, i[1:0])));
        $display("test map done");
    end
    endtask

    task t_rst2;
    begin
        wr(`IDX_HS_ZERO, 8'hff, `RESP_OKAY);
        co(2'd0, 32'h7f);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        co(2'd0, 32'h0c);
        rd(`IDX_HS_ZERO, 32'h0c, `RESP_OKAY);
        $display("test second reset done");
    end
    endtask

    // Read held while enable is low, answered once enable returns
    task t_ce;
        integer n;
        reg     done;
    begin
        done = 1'b0;
        ce <= 1'b0;
        s_axi_araddr <= {22'h0, `IDX_HS_EXIT, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 3; n = n + 1)
        begin
            @(posedge aclk);
            chk("frozen rvalid", 32'(s_axi_rvalid), 32'h0);
        end
        ce <= 1'b1;
        for (n = 0; n < 40 && !done; n = n + 1)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                done = 1'b1;
                chk("rdata", s_axi_rdata, 32'(av(`RATE_800, 2'd2)));
                s_axi_rready <= 1'b0;
            end
        end
        if (!done)
            tmo;
        @(posedge aclk);
        $display("test enable done");
    end
    endtask

    // Main sequence
    initial
    begin
        aresetn = 1'b0;
        ce = 1'b1;
        s_axi_wstrb = 4'hf;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_override;
        t_rate;
        t_map;
        t_ce;
        t_rst2;
        summarize;
    end
endmodule
